// File: hdl/ptme_cfg.svh
// register offsets, field positions, reset values and mode codes of the timer
`ifndef PTME_CFG_SVH
`define PTME_CFG_SVH

// register offsets on the plain register port
`define PTME_OFS_COUNT 2'h0
`define PTME_OFS_PERIOD 2'h1
`define PTME_OFS_CTRL 2'h2
`define PTME_OFS_MODE 2'h3

// field positions
`define PTME_RUN_BIT 7
`define PTME_MODE_MSB 4

// reset values
`define PTME_RST_COUNT 8'h00
`define PTME_RST_PERIOD 8'hFF
`define PTME_RST_MODE 5'h00

// mode codes
`define PTME_M_SW_GATE 5'h00
`define PTME_M_GATE_HI 5'h01
`define PTME_M_GATE_LO 5'h02
`define PTME_M_LIM_ANY 5'h03
`define PTME_M_LIM_RISE 5'h04
`define PTME_M_LIM_FALL 5'h05
`define PTME_M_LVL_LO 5'h06
`define PTME_M_LVL_HI 5'h07
`define PTME_M_OS_SW 5'h08
`define PTME_M_OS_RISE 5'h09
`define PTME_M_OS_FALL 5'h0A
`define PTME_M_OS_ANY 5'h0B
`define PTME_M_OSL_RISE 5'h0C
`define PTME_M_OSL_FALL 5'h0D
`define PTME_M_OSV_LO 5'h0E
`define PTME_M_OSV_HI 5'h0F

`endif

// File: hdl/ptme_pkg.sv
// types shared by the period timer mode engine
package ptme_pkg;

    // whole state of the timer, registered as one word
    typedef struct packed {
        logic run;
        logic [4:0] mode;
        logic [7:0] period;
        logic [7:0] count;
        logic sync1;
        logic sync2;
        logic sync3;
        logic started;
        logic match;
        logic [7:0] rdata;
    } ptme_state_t;

endpackage

// File: hdl/ptme_timer.sv
// period timer mode engine: counter, mode decode and register port
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "ptme_cfg.svh"

// Operation
// RULE1: software gate: count up each clock while run set, hold while clear
// RULE2: on period match the count goes to zero next clock and keeps counting
// RULE3: hardware gate pauses on high input (00001) or low input (00010)
// RULE4: edge limit modes clear count early on any, rising or falling edge
// RULE5: after an early edge reset, counting restarts two clocks later
// RULE6: level limit holds count reset at low (00110) or high (00111) level
// RULE7: level limit ignores the external signal while run is clear
// RULE8: level limit resets at period match or two clocks after active level
// RULE9: level limit resumes after match or two clocks after release
// RULE10: software one-shot clears count and run bit at period match
// RULE11: software one-shot pauses and resumes on run toggles, no restart
// RULE12: software restarts a one-shot only by setting run after it cleared
// RULE13: edge one-shot starts on selected edge after run set, clears run at match
// RULE14: edge one-shot needs a fresh edge after run is set again
// RULE15: edge limit one-shot starts on first edge, later edges reset count
// RULE16: edge limit one-shot ignores edges until run set, clears run at match
// RULE17: level-reset one-shot holds at reset level, starts on active edge
// RULE18: level-reset one-shot clears run at match, needs new edge to start
// RULE19: with run clear all internal state machines are held in reset
// RULE20: in one-shot modes the clock after match clears run, count stops at 0
// RULE21: external signal passes a two-flop synchroniser; edges come from it
module ptme_timer
    import ptme_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic ext_reset_signal_in,
    output logic [7:0] rdata_out,
    output logic [7:0] timer_count_out,
    output logic run_out,
    output logic period_match_out
);

    ptme_state_t q;
    ptme_state_t d;
    logic rise;
    logic fall;
    logic hit;
    logic adv;
    logic clr;
    logic oneshot;

    // true when the mode clears run at period match
    function automatic logic is_oneshot(input logic [4:0] m);
        is_oneshot = (m >= `PTME_M_OS_SW) && (m <= `PTME_M_OSV_HI);
    endfunction

    // edge qualifier: 0 any, 1 rising, 2 falling
    function automatic logic edge_sel(input logic [1:0] k, input logic r,
                                      input logic f);
        unique case (k)
            2'h1: edge_sel = r;
            2'h2: edge_sel = f;
            default: edge_sel = r | f;
        endcase
    endfunction

    // edges from the synchronised copy only
    assign rise = q.sync2 & ~q.sync3; // [RULE21]
    assign fall = ~q.sync2 & q.sync3; // [RULE21]
    assign hit = (q.count == q.period);

    // next state
    always_comb begin
        d = q;
        adv = 1'b0;
        clr = 1'b0;
        oneshot = is_oneshot(q.mode);
        d.match = 1'b0;
        d.rdata = 8'h00;
        // two-flop synchroniser, third flop for edges
        d.sync1 = ext_reset_signal_in; // [RULE21]
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;
        if (!q.run) begin
            // count holds, start trackers reset, input ignored
            d.started = 1'b0; // [RULE19] [RULE7] [RULE14] [RULE18]
        end else begin
            unique case (q.mode)
                `PTME_M_SW_GATE, `PTME_M_OS_SW: begin
                    adv = 1'b1; // [RULE1] [RULE11]
                end
                `PTME_M_GATE_HI: begin
                    adv = ~q.sync2; // [RULE3]
                end
                `PTME_M_GATE_LO: begin
                    adv = q.sync2; // [RULE3]
                end
                `PTME_M_LIM_ANY, `PTME_M_LIM_RISE, `PTME_M_LIM_FALL: begin
                    // early clear, count resumes next clock
                    if (edge_sel(q.mode[1:0] + 2'h1, rise, fall)) begin
                        clr = 1'b1; // [RULE4] [RULE5]
                    end else begin
                        adv = 1'b1;
                    end
                end
                `PTME_M_LVL_LO: begin
                    clr = ~q.sync2; // [RULE6] [RULE8]
                    adv = q.sync2; // [RULE9]
                end
                `PTME_M_LVL_HI: begin
                    clr = q.sync2; // [RULE6] [RULE8]
                    adv = ~q.sync2; // [RULE9]
                end
                `PTME_M_OS_RISE, `PTME_M_OS_FALL, `PTME_M_OS_ANY: begin
                    if (q.started) begin
                        adv = 1'b1;
                    end else if (edge_sel(q.mode[1:0], rise, fall)) begin
                        d.started = 1'b1; // [RULE13]
                    end
                end
                `PTME_M_OSL_RISE, `PTME_M_OSL_FALL: begin
                    if (!q.started) begin
                        d.started = q.mode[0] ? fall : rise; // [RULE15] [RULE16]
                    end else if (q.mode[0] ? fall : rise) begin
                        clr = 1'b1; // [RULE15]
                    end else begin
                        adv = 1'b1;
                    end
                end
                `PTME_M_OSV_LO, `PTME_M_OSV_HI: begin
                    // reset level: low for 01110, high for 01111
                    if (q.sync2 == q.mode[0]) begin
                        clr = 1'b1; // [RULE17]
                    end else if (q.started) begin
                        adv = 1'b1;
                    end
                    if (q.mode[0] ? fall : rise) begin
                        d.started = 1'b1; // [RULE17]
                    end
                end
                default: begin
                    clr = 1'b1; // unsupported codes park at zero
                end
            endcase
        end
        // counter update
        if (clr) begin
            d.count = `PTME_RST_COUNT;
        end else if (adv) begin
            if (hit) begin
                d.count = `PTME_RST_COUNT; // [RULE2]
                d.match = 1'b1;
                if (oneshot) begin
                    d.run = 1'b0; // [RULE10] [RULE13] [RULE16] [RULE18] [RULE20]
                    d.started = 1'b0;
                end
            end else begin
                d.count = q.count + 8'h01; // [RULE1]
            end
        end
        // register writes; a run write wins over the hardware clear
        if (wr_in) begin
            unique case (addr_in)
                `PTME_OFS_COUNT: d.count = wdata_in;
                `PTME_OFS_PERIOD: d.period = wdata_in;
                `PTME_OFS_CTRL: d.run = wdata_in[`PTME_RUN_BIT]; // [RULE12]
                `PTME_OFS_MODE: d.mode = wdata_in[`PTME_MODE_MSB:0];
            endcase
        end
        // read data stands in the cycle after the strobe
        if (rd_in) begin
            unique case (addr_in)
                `PTME_OFS_COUNT: d.rdata = q.count;
                `PTME_OFS_PERIOD: d.rdata = q.period;
                `PTME_OFS_CTRL: d.rdata = {q.run, 7'h00};
                `PTME_OFS_MODE: d.rdata = {3'h0, q.mode};
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            q <= '0;
            q.period <= `PTME_RST_PERIOD;
            q.mode <= `PTME_RST_MODE;
            q.count <= `PTME_RST_COUNT;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state flops
    assign rdata_out = q.rdata;
    assign timer_count_out = q.count;
    assign run_out = q.run;
    assign period_match_out = q.match;

    // software gate advances by one
    a_sw_gate_count: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE1]
        (q.run && q.mode == `PTME_M_SW_GATE && !hit && !wr_in)
        |=> (q.count == 8'($past(q.count) + 8'h01)))
        else $error("count did not advance in software gate");

    // period match wraps to zero; a zero period matches again at once
    a_period_wrap_zero: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE2]
        (q.run && q.mode == `PTME_M_SW_GATE && hit && !wr_in)
        |=> (q.count == 8'h00)
        ##1 (q.count == 8'h01 || q.period == 8'h00 || !q.run || $past(wr_in)))
        else $error("count did not wrap at period");

    // hardware gate pauses on high input
    a_gate_pause_hi: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE3]
        (q.run && q.mode == `PTME_M_GATE_HI && q.sync2 && !wr_in)
        |=> $stable(q.count))
        else $error("gate did not pause count");

    // rising edge limit clears the count
    a_edge_limit_clear: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE4]
        (q.run && q.mode == `PTME_M_LIM_RISE && rise && !wr_in)
        |=> (q.count == 8'h00))
        else $error("edge did not clear count");

    // synchroniser delay of two clocks
    a_sync_two_clk: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE21] [RULE5]
        ##2 (q.sync2 == $past(ext_reset_signal_in, 2)))
        else $error("synchroniser delay wrong");

    // level limit holds reset at high level
    a_level_reset_hi: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE6]
        (q.run && q.mode == `PTME_M_LVL_HI && q.sync2 && !wr_in)
        |=> (q.count == 8'h00))
        else $error("level did not hold count reset");

    // external signal ignored while run clear
    a_level_run_off: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE7]
        (!q.run && q.mode == `PTME_M_LVL_LO && !wr_in)
        |=> $stable(q.count))
        else $error("count moved while run clear");

    // one-shot match clears run and parks at zero
    a_oneshot_stop: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE10] [RULE20]
        (q.run && q.mode == `PTME_M_OS_SW && hit && !wr_in)
        |=> (!q.run && q.count == 8'h00 && q.match))
        else $error("one-shot did not stop at match");

    // edge one-shot waits for its edge
    a_edge_wait: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE13] [RULE14]
        (q.mode == `PTME_M_OS_RISE && !q.started && !wr_in)
        |=> $stable(q.count))
        else $error("edge one-shot counted without edge");

    // run clear drops the start tracker
    a_run_clear_idle: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE19]
        (!q.run && !(wr_in && addr_in == `PTME_OFS_CTRL)) |=> !q.started)
        else $error("state not reset while run clear");

    // hardware gate pauses on low input
    a_gate_pause_lo: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE3]
        (q.run && q.mode == `PTME_M_GATE_LO && !q.sync2 && !wr_in)
        |=> $stable(q.count))
        else $error("low gate did not pause count");

    // level limit holds reset at low level
    a_level_reset_lo: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE6] [RULE8]
        (q.run && q.mode == `PTME_M_LVL_LO && !q.sync2 && !wr_in)
        |=> (q.count == 8'h00))
        else $error("low level did not hold count reset");

    // level limit counts once the reset level is released
    a_level_resume: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE9]
        (q.run && q.mode == `PTME_M_LVL_HI && !q.sync2 && !hit && !wr_in)
        |=> (q.count == 8'($past(q.count) + 8'h01)))
        else $error("level limit did not resume counting");

    // software one-shot holds its count while run is clear
    a_oneshot_pause: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE11]
        (!q.run && q.mode == `PTME_M_OS_SW && !wr_in)
        |=> ($stable(q.count) && !q.run))
        else $error("one-shot count moved while paused");

    // edge one-shot arms on its rising edge
    a_edge_start: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE13]
        (q.run && q.mode == `PTME_M_OS_RISE && !q.started && rise)
        |=> q.started)
        else $error("edge one-shot did not start on edge");

    // later edges in limit one-shot clear the count
    a_limit_shot_clear: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE15]
        (q.run && q.mode == `PTME_M_OSL_RISE && q.started && rise && !wr_in)
        |=> (q.count == 8'h00))
        else $error("limit one-shot edge did not clear count");

    // level-reset one-shot holds zero at the reset level
    a_level_shot_hold: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE17]
        (q.run && q.mode == `PTME_M_OSV_LO && !q.sync2 && !wr_in)
        |=> (q.count == 8'h00))
        else $error("level one-shot did not hold count reset");

    // any one-shot match drops run and the start tracker
    a_shot_stop: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE18] [RULE20]
        (q.run && is_oneshot(q.mode) && adv && !clr && hit
            && !(wr_in && addr_in == `PTME_OFS_CTRL)) |=> (!q.run && !q.started))
        else $error("one-shot match did not stop");

endmodule // ptme_timer

// File: testbench/ptme_partner.sv
// far side model: external reset source and pwm compare unit
`timescale 1ns/1ps
module ptme_partner (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ext_req_in,
    input wire logic [7:0] timer_count_in,
    input wire logic [7:0] pulse_width_value_in,
    output logic ext_reset_signal_out,
    output logic pwm_out
);
    // source launches its level on the clock, compare follows the count
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ext_reset_signal_out <= 1'b0;
            pwm_out <= 1'b0;
        end else begin
            ext_reset_signal_out <= ext_req_in;
            pwm_out <= (timer_count_in < pulse_width_value_in);
        end
    end
endmodule // ptme_partner

// File: testbench/ptme_timer_tb.sv
// self-checking bench of the period timer mode engine
`timescale 1ns/1ps
`include "ptme_cfg.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module ptme_timer_tb;
    logic clk_in = 1'b0, reset_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, ext_req = 1'b0;
    logic [1:0] addr_in = 2'h0;
    logic [7:0] wdata_in = 8'h00, rdata, cnt, p, prev;
    logic ext_sig, pwm, run, match, lv;
    logic [31:0] seed = 32'h0000C461, r;
    int err_count = 0, check_count = 0, cyc = 0, k, m, e;

    ptme_timer DUT (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .ext_reset_signal_in(ext_sig),
        .rdata_out(rdata), .timer_count_out(cnt), .run_out(run), .period_match_out(match));
    ptme_partner PARTNER (.clk_in(clk_in), .reset_in(reset_in), .ext_req_in(ext_req),
        .timer_count_in(cnt), .pulse_width_value_in(8'h02), .ext_reset_signal_out(ext_sig),
        .pwm_out(pwm));

    // clock and hang guard
    initial forever #50 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end

    // helpers: random source, next count, bus cycles, waits
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [7:0] adv(input logic [7:0] c, input logic [7:0] pv);
        return (c == pv) ? 8'h00 : c + 8'h01;
    endfunction
    task tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    task rd(input logic [1:0] a, input logic [7:0] x);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        `CHK(rdata, x)
    endtask
    task runbit(input logic v);
        wr(`PTME_OFS_CTRL, {v, 7'h00});
    endtask
    task ext(input logic v, input int n);
        @(posedge clk_in);
        ext_req <= v;
        tick(n);
    endtask
    task go(input int md, input logic [7:0] pv);
        runbit(1'b0);
        wr(`PTME_OFS_MODE, 8'(md));
        wr(`PTME_OFS_PERIOD, pv);
        wr(`PTME_OFS_COUNT, 8'h00);
    endtask
    task wait_m();
        for (int i = 0; i < 40 && match !== 1'b1; i++) tick(1);
    endtask
    task complete_run();
        $display("errors=%0d checks=%0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (10) @(posedge clk_in);
        reset_in <= 1'b0;
        tick(1);
        rd(`PTME_OFS_COUNT, `PTME_RST_COUNT);
        rd(`PTME_OFS_PERIOD, `PTME_RST_PERIOD);
        rd(`PTME_OFS_CTRL, 8'h00);
        rd(`PTME_OFS_MODE, {3'h0, `PTME_RST_MODE});
        // free run and hardware gates under random external level
        for (k = 0; k < 3; k++) begin
            r = xs();
            p = {4'h0, r[3:0]} | 8'h02;
            go(k, p);
            runbit(1'b1);
            for (int i = 0; i < 60; i++) begin
                prev = cnt;
                r = xs();
                @(posedge clk_in);
                ext_req <= r[0];
                #1;
                if (k == 0) `CHK(cnt, adv(prev, p))
                else `CHK((cnt === prev) || (cnt === adv(prev, p)), 1'b1)
            end
            if (k > 0) begin
                ext(k == 1, 4);
                prev = cnt;
                tick(5);
                `CHK(cnt, prev)
                ext(k != 1, 4);
                prev = cnt;
                tick(1);
                `CHK(cnt, adv(prev, p))
            end
            runbit(1'b0);
            prev = cnt;
            tick(5);
            `CHK(cnt, prev)
        end
        // edge limit: every mode against both edge kinds
        for (m = 3; m < 6; m++) begin
            go(m, 8'hFF);
            ext(1'b0, 4);
            runbit(1'b1);
            for (e = 0; e < 2; e++) begin
                tick(6);
                ext(e == 0, 4);
                if (m == 3 || (m == 4 && e == 0) || (m == 5 && e == 1)) begin
                    `CHK({pwm, cnt}, 9'h000)
                    tick(1);
                    `CHK({pwm, cnt}, 9'h101)
                end else `CHK(cnt === 8'h00, 1'b0)
            end
        end
        // level limit: hold, release, ignored while stopped
        for (m = 6; m < 8; m++) begin
            lv = (m == 7);
            go(m, 8'hFF);
            ext(!lv, 4);
            runbit(1'b1);
            tick(6);
            ext(lv, 4);
            `CHK(cnt, 8'h00)
            tick(4);
            `CHK(cnt, 8'h00)
            ext(!lv, 6);
            `CHK(cnt === 8'h00, 1'b0)
            runbit(1'b0);
            prev = cnt;
            ext(lv, 6);
            `CHK(cnt, prev)
        end
        // software one-shot, then pause and resume mid-cycle
        go(8, 8'h04);
        runbit(1'b1);
        wait_m();
        `CHK({match, run, cnt}, 10'h200)
        tick(3);
        `CHK({run, cnt}, 9'h000)
        go(8, 8'h10);
        runbit(1'b1);
        tick(5);
        runbit(1'b0);
        prev = cnt;
        tick(4);
        `CHK(cnt, prev)
        runbit(1'b1);
        tick(1);
        `CHK(cnt, prev + 8'h01)
        wait_m();
        `CHK({match, run, cnt}, 10'h200)
        // edge started one-shots, restart needs a fresh edge
        for (m = 9; m < 12; m++) begin
            lv = (m == 10);
            go(m, 8'h03);
            ext(lv, 4);
            runbit(1'b1);
            tick(6);
            `CHK(cnt, 8'h00)
            ext(!lv, 1);
            wait_m();
            `CHK({match, run, cnt}, 10'h200)
            runbit(1'b1);
            tick(6);
            `CHK(cnt, 8'h00)
        end
        // edge limit one-shot, both polarities: edges ignored while stopped
        for (m = 12; m < 14; m++) begin
            lv = (m == 13);
            go(m, 8'hFF);
            ext(!lv, 4);
            ext(lv, 4);
            runbit(1'b1);
            tick(6);
            `CHK(cnt, 8'h00)
            ext(!lv, 8);
            `CHK(cnt === 8'h00, 1'b0)
            ext(lv, 4);
            ext(!lv, 4);
            `CHK(cnt, 8'h00)
            tick(1);
            `CHK(cnt, 8'h01)
        end
        // level reset one-shot, low and high reset level
        for (m = 14; m < 16; m++) begin
            lv = (m == 15);
            go(m, 8'h03);
            ext(lv, 4);
            runbit(1'b1);
            tick(6);
            `CHK(cnt, 8'h00)
            ext(!lv, 1);
            wait_m();
            `CHK({match, run, cnt}, 10'h200)
            runbit(1'b1);
            tick(6);
            `CHK(cnt, 8'h00)
        end
        complete_run();
    end
endmodule // ptme_timer_tb
